// [hw/rdp_cfg.svh]
// Constants for the radio data decoder configuration and status pins
`ifndef RDP_CFG_SVH
`define RDP_CFG_SVH

// ****************************************
// Configuration word layout
// ****************************************
`define RDP_CFG_W 16
`define RDP_EC_LO 0
`define RDP_EC_HI 2
`define RDP_DM_LO 3
`define RDP_DM_HI 4
`define RDP_XS 5
`define RDP_PL_LOCK 6
`define RDP_PL_SEL 7
`define RDP_RM 8
`define RDP_PT0 9
`define RDP_PT1 10
`define RDP_PT2 11
`define RDP_CFG_RESET 16'h0692

// ****************************************
// Field codes
// ****************************************
`define RDP_LIMIT_MAX 3'h5
`define RDP_DM_HARD 2'h0
`define RDP_DM_SOFT_A 2'h1
`define RDP_DM_SOFT_B 2'h2
`define RDP_DM_BAD 2'h3
// Decoded reset word: limit 2, soft B, phase auto, select 1
`define RDP_CORE_RESET 10'h14c
`define RDP_ERR_UNCORR 3'h6
`define RDP_MODE_OFF 2'h0
`define RDP_MODE_CLK 2'h1
`define RDP_MODE_ERR 2'h3

// ****************************************
// Status pin indexes
// ****************************************
`define RDP_NPIN 7
`define RDP_P_T3 0
`define RDP_P_T4 1
`define RDP_P_T5 2
`define RDP_P_T6 3
`define RDP_P_T7 4
`define RDP_P_SYNC 5
`define RDP_P_RDSID 6

// ****************************************
// Statistics and timing
// ****************************************
`define RDP_WIN_BLOCKS 48
`define RDP_BE_STEP1 20
`define RDP_BE_STEP2 40
`define RDP_CLK_NS 20
`define RDP_SYNC_PULSE_NS 421000

`endif

// [hw/rdp_pkg.sv]
// Types shared by the radio data decoder configuration and status logic
package rdp_pkg;

  // Decoded settings handed to the decoder core
  typedef struct packed {
    logic [2:0] corr_limit;
    logic soft_on;
    logic soft_restrain;
    logic xtal_fast;
    logic phase_auto;
    logic phase_zero_deg;
    logic offset_e_en;
    logic illegal;
  } rdp_core_cfg_t;

  // Per-cycle status coming from the decoder core
  typedef struct packed {
    logic block_done;
    logic [3:0] bit_errs;
    logic block_start;
    logic in_sync;
    logic data_clk;
    logic data_bit;
    logic shift;
    logic sub_clk;
    logic traffic;
    logic rds_present;
  } rdp_core_stat_t;

endpackage

// [hw/rdp_link_rx.sv]
// Serial control bus shift register on the host's bus clock
`timescale 1ns/1ps
`default_nettype none
`include "rdp_cfg.svh"

module rdp_link_rx #(
  parameter int W = `RDP_CFG_W
) (
  // Link side
  input wire logic ctl_clk,
  input wire logic ctl_en,
  input wire logic ctl_data,
  // Captured word
  output logic [W-1:0] word_reg
);

  initial begin
    if (W < 12) $error("rdp_link_rx: word too short");
  end

  // Shift LSB first; the bus clock stops between frames, so the word
  // holds still once the frame strobe drops
  always_ff @(posedge ctl_clk) begin
    if (ctl_en) begin
      word_reg <= {ctl_data, word_reg[W-1:1]};
    end
  end

endmodule // rdp_link_rx
`default_nettype wire

// [hw/rdp_status_pins.sv]
// Configuration register and open-drain status pin logic of the data decoder
//
// Contract
// (RULE1) Three-bit limit selects corrected bits, zero to five
// (RULE2) Two-bit field selects hard, soft A, soft B
// (RULE3) Reset: limit two bits, decision soft B
// (RULE4) Soft modes stay active with limit zero
// (RULE5) Soft A restrains correction relative to B
// (RULE6) Crystal bit picks 4.332 or 8.664 MHz
// (RULE7) Unlocked phase is automatic, start from select
// (RULE8) Locked phase fixed: 90 or 0 degrees
// (RULE9) Reset: phase unlocked, phase select one
// (RULE10) Support bit enables offset word E detection
// (RULE11) Output mode enables status pins per mode
// (RULE12) Reset output mode three
// (RULE13) Polarity bit makes several pins active high
// (RULE14) Data changes on clock pin edge per polarity
// (RULE15) Error, correction and traffic pin levels
// (RULE16) Mode four: errored blocks per 48, fixed polarity
// (RULE17) Modes 0-2: sync pin low when synchronized
// (RULE18) Mode three: 421 us sync pulse per block
// (RULE19) Sync pin shows previous block's state
// (RULE20) Host keeps test bits at zero
// (RULE21) Errors above limit flag block uncorrectable
// (RULE22) New settings apply together after transfer end
// (RULE23) Illegal codes flagged, behaviour undefined
`timescale 1ns/1ps
`default_nettype none
`include "rdp_cfg.svh"

module rdp_status_pins
  import rdp_pkg::*;
#(
  parameter int SYNC_PULSE_CYC = (`RDP_SYNC_PULSE_NS + `RDP_CLK_NS - 1) / `RDP_CLK_NS,
  parameter int WIN_BLOCKS = `RDP_WIN_BLOCKS
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Serial control bus
  input wire logic ctl_clk,
  input wire logic ctl_en,
  input wire logic ctl_data,
  // Decoder core
  input wire rdp_core_stat_t stat,
  output rdp_core_cfg_t core_cfg_reg,
  output logic [2:0] err_code_reg,
  // Open-drain status pins
  output logic [`RDP_NPIN-1:0] pin_o_reg,
  output logic [`RDP_NPIN-1:0] pin_oe_reg
);

  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (SYNC_PULSE_CYC < 8 || SYNC_PULSE_CYC > 65535) $error("bad sync pulse length");
    if (WIN_BLOCKS < `RDP_BE_STEP2 + 1 || WIN_BLOCKS > 63) $error("bad block window");
  end

  // ****************************************
  // Link capture and crossing
  // ****************************************
  logic [`RDP_CFG_W-1:0] link_word; // Stable while frame strobe low
  logic en_s1_reg; // First synchroniser stage
  logic en_s2_reg; // Second stage
  logic en_s3_reg; // Edge history
  logic frame_end; // One-cycle end-of-transfer pulse

  rdp_link_rx #(.W(`RDP_CFG_W)) u_link (
    .ctl_clk(ctl_clk),
    .ctl_en(ctl_en),
    .ctl_data(ctl_data),
    .word_reg(link_word)
  );

  // Strobe passes two flops before any logic reads it
  always_ff @(posedge clk) begin
    if (srst) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      en_s3_reg <= 1'b0;
    end else begin
      en_s1_reg <= ctl_en;
      en_s2_reg <= en_s1_reg;
      en_s3_reg <= en_s2_reg;
    end
  end

  assign frame_end = en_s3_reg & ~en_s2_reg;

  // ****************************************
  // Configuration register and decode
  // ****************************************
  logic [`RDP_CFG_W-1:0] cfg_reg; // Raw settings in force
  logic [`RDP_CFG_W-1:0] cfg_next;
  rdp_core_cfg_t core_cfg_next;
  wire [2:0] lim_f = cfg_next[`RDP_EC_HI:`RDP_EC_LO];
  wire [1:0] dm_f = cfg_next[`RDP_DM_HI:`RDP_DM_LO];

  // Whole word swaps in one cycle, never a half-shifted one
  assign cfg_next = frame_end ? link_word : cfg_reg; // RULE22

  // Core settings decoded from the word about to take effect
  always_comb begin
    core_cfg_next.corr_limit = lim_f; // RULE1
    core_cfg_next.soft_on = (dm_f != `RDP_DM_HARD); // RULE2 RULE4
    core_cfg_next.soft_restrain = (dm_f == `RDP_DM_SOFT_A); // RULE5
    core_cfg_next.xtal_fast = cfg_next[`RDP_XS]; // RULE6
    core_cfg_next.phase_auto = ~cfg_next[`RDP_PL_LOCK]; // RULE7
    core_cfg_next.phase_zero_deg = cfg_next[`RDP_PL_SEL]; // RULE7 RULE8
    core_cfg_next.offset_e_en = cfg_next[`RDP_RM]; // RULE10
    core_cfg_next.illegal = (lim_f > `RDP_LIMIT_MAX) || (dm_f == `RDP_DM_BAD); // RULE23
  end

  // Reset word carries every documented power-on default
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_reg <= `RDP_CFG_RESET; // RULE3 RULE9 RULE12
      core_cfg_reg <= `RDP_CORE_RESET; // RULE3 RULE9
    end else begin
      cfg_reg <= cfg_next;
      core_cfg_reg <= core_cfg_next;
    end
  end

  // ****************************************
  // Block error flags
  // ****************************************
  logic uncorr_reg; // Last block could not be corrected
  logic clean_reg; // Last block had no errors
  wire over_limit = stat.bit_errs > {1'b0, core_cfg_reg.corr_limit};
  wire had_err = (stat.bit_errs != 4'h0);

  // Above the limit the block is flagged uncorrectable
  always_ff @(posedge clk) begin
    if (srst) begin
      err_code_reg <= 3'h0;
      uncorr_reg <= 1'b0;
      clean_reg <= 1'b1;
    end else if (stat.block_done) begin
      err_code_reg <= over_limit ? `RDP_ERR_UNCORR : stat.bit_errs[2:0]; // RULE21
      uncorr_reg <= over_limit; // RULE21
      clean_reg <= ~had_err;
    end
  end

  // ****************************************
  // Error statistics over a block window
  // ****************************************
  logic [5:0] win_cnt_reg; // Blocks seen in this window
  logic [5:0] bad_cnt_reg; // Errored blocks in this window
  logic [1:0] be_code_reg; // Latched two-bit count
  wire [5:0] bad_total = bad_cnt_reg + {5'h0, had_err};
  wire win_last = (win_cnt_reg == 6'(WIN_BLOCKS - 1));
  wire [1:0] be_code_next = (bad_total == 6'h0) ? 2'h0 :
                            (bad_total <= 6'(`RDP_BE_STEP1)) ? 2'h1 :
                            (bad_total <= 6'(`RDP_BE_STEP2)) ? 2'h2 : 2'h3;

  // Code only moves at window end so the pins never show a partial count
  always_ff @(posedge clk) begin
    if (srst) begin
      win_cnt_reg <= 6'h0;
      bad_cnt_reg <= 6'h0;
      be_code_reg <= 2'h0;
    end else if (stat.block_done) begin
      win_cnt_reg <= win_last ? 6'h0 : win_cnt_reg + 6'h1;
      bad_cnt_reg <= win_last ? 6'h0 : bad_total;
      if (win_last) begin
        be_code_reg <= be_code_next; // RULE16
      end
    end
  end

  // ****************************************
  // Sync indication
  // ****************************************
  logic prev_sync_reg; // State during the previous block
  logic [15:0] pulse_cnt_reg; // Remaining pulse cycles

  // State latched at block end, so the pin lags by one block
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_sync_reg <= 1'b0;
    end else if (stat.block_done) begin
      prev_sync_reg <= stat.in_sync; // RULE19
    end
  end

  // Pulse timer restarts on every block start
  always_ff @(posedge clk) begin
    if (srst) begin
      pulse_cnt_reg <= 16'h0;
    end else if (stat.block_start) begin
      pulse_cnt_reg <= 16'(SYNC_PULSE_CYC); // RULE18
    end else if (pulse_cnt_reg != 16'h0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 16'h1;
    end
  end

  // ****************************************
  // Recovered data path
  // ****************************************
  logic dclk_reg; // Core data clock, one cycle late
  logic data_reg; // Data bit held for the pin
  logic shift_reg; // Shift strobe held for the pin
  wire dclk_rise = stat.data_clk & ~dclk_reg;

  // Data and clock pin move in the same cycle, on the launching edge
  always_ff @(posedge clk) begin
    if (srst) begin
      // High at reset so a data clock already high gives no false edge
      dclk_reg <= 1'b1;
      data_reg <= 1'b0;
      shift_reg <= 1'b0;
    end else begin
      dclk_reg <= stat.data_clk;
      if (dclk_rise) begin
        data_reg <= stat.data_bit; // RULE14
        shift_reg <= stat.shift; // RULE14
      end
    end
  end

  // ****************************************
  // Pin mode decode
  // ****************************************
  wire pol = cfg_reg[`RDP_PT2]; // RULE13
  wire [1:0] base = {cfg_reg[`RDP_PT1], cfg_reg[`RDP_PT0]};
  wire mode4 = pol & (base == `RDP_MODE_OFF);
  wire en_main = ~mode4 & (base != `RDP_MODE_OFF); // RULE11
  wire en_t67 = mode4 | (base[1] & ~mode4); // RULE11
  wire mode3 = ~mode4 & (base == `RDP_MODE_ERR);
  wire dclk_next = stat.data_clk;
  wire pulse_on = mode3 & (pulse_cnt_reg != 16'h0);
  wire sync_raw = ~prev_sync_reg | (prev_sync_reg & pulse_on); // RULE17 RULE18

  // Logical levels per pin; the pull-up makes a released pin read high
  logic [`RDP_NPIN-1:0] lvl_next;
  logic [`RDP_NPIN-1:0] en_next;
  always_comb begin
    lvl_next = '1;
    en_next = '0;
    lvl_next[`RDP_P_T3] = dclk_next ^ pol; // RULE13 RULE14
    lvl_next[`RDP_P_T4] = dclk_rise ? stat.data_bit : data_reg;
    lvl_next[`RDP_P_T5] = dclk_rise ? stat.shift : shift_reg;
    en_next[`RDP_P_T3] = en_main;
    en_next[`RDP_P_T4] = en_main;
    en_next[`RDP_P_T5] = en_main;
    en_next[`RDP_P_T6] = en_t67;
    en_next[`RDP_P_T7] = en_t67;
    if (mode4) begin
      // Fixed polarity, independent of the polarity bit
      lvl_next[`RDP_P_T6] = be_code_reg[1]; // RULE16
      lvl_next[`RDP_P_T7] = be_code_reg[0]; // RULE16
    end else if (mode3) begin
      lvl_next[`RDP_P_T6] = ~uncorr_reg ^ pol; // RULE15
      lvl_next[`RDP_P_T7] = clean_reg ^ pol; // RULE15
    end else begin
      lvl_next[`RDP_P_T6] = stat.sub_clk ^ pol;
      lvl_next[`RDP_P_T7] = ~stat.traffic ^ pol; // RULE15
    end
    lvl_next[`RDP_P_SYNC] = sync_raw ^ pol; // RULE13
    lvl_next[`RDP_P_RDSID] = ~stat.rds_present ^ pol; // RULE13
    en_next[`RDP_P_SYNC] = 1'b1;
    en_next[`RDP_P_RDSID] = 1'b1;
  end

  // ****************************************
  // Open-drain drivers
  // ****************************************
  logic [`RDP_NPIN-1:0] lvl_reg; // Intended level, for checking only

  // A pin is only ever pulled low; high comes from the external resistor
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_o_reg <= '0;
      pin_oe_reg <= '0;
      lvl_reg <= '1;
    end else begin
      pin_o_reg <= '0;
      pin_oe_reg <= en_next & ~lvl_next; // RULE11
      lvl_reg <= lvl_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_pulse_start;
    stat.block_start && mode3 && !pol && prev_sync_reg && !stat.block_done;
  endsequence

  sequence s_pulse_high;
    lvl_reg[`RDP_P_SYNC] [*8];
  endsequence

  a_reset_defaults: assert property (@(posedge clk) // RULE3
    $fell(srst) |-> core_cfg_reg.corr_limit == 3'h2 && core_cfg_reg.soft_on
      && !core_cfg_reg.soft_restrain && cfg_reg[`RDP_PT0] && cfg_reg[`RDP_PT1])
    else $error("reset defaults wrong");

  a_cfg_atomic: assert property (@(posedge clk) disable iff (srst) // RULE22
    !frame_end |=> $stable(cfg_reg))
    else $error("settings changed outside transfer end");

  a_uncorr_flag: assert property (@(posedge clk) disable iff (srst) // RULE21
    stat.block_done && over_limit |=> err_code_reg == `RDP_ERR_UNCORR)
    else $error("block over limit not flagged");

  a_soft_zero: assert property (@(posedge clk) disable iff (srst) // RULE4
    cfg_reg[`RDP_DM_HI:`RDP_DM_LO] == `RDP_DM_SOFT_B |-> core_cfg_reg.soft_on
      && !core_cfg_reg.soft_restrain)
    else $error("soft decision lost");

  a_mode0_open: assert property (@(posedge clk) disable iff (srst) // RULE11
    frame_end ##0 (cfg_next[`RDP_PT2:`RDP_PT0] == 3'h0) ##1 !frame_end
      |=> pin_oe_reg[`RDP_P_T7:`RDP_P_T3] == 5'h0)
    else $error("pin driven in mode 0");

  a_be_window: assert property (@(posedge clk) disable iff (srst) // RULE16
    !(stat.block_done && win_last) |=> $stable(be_code_reg))
    else $error("block error code moved inside a window");

  a_sync_pulse: assert property (@(posedge clk) disable iff (srst) // RULE18
    s_pulse_start |-> ##2 s_pulse_high)
    else $error("sync pulse missing");

  a_sync_unsync: assert property (@(posedge clk) disable iff (srst) // RULE17
    !prev_sync_reg && !pol && !stat.block_done |=> lvl_reg[`RDP_P_SYNC])
    else $error("sync pin low while unsynchronized");

  a_data_edge: assert property (@(posedge clk) disable iff (srst) // RULE14
    !pol && !$past(pol) && !$past(srst, 2) && $changed(lvl_reg[`RDP_P_T4])
      |-> $rose(lvl_reg[`RDP_P_T3]))
    else $error("data changed away from clock edge");

endmodule // rdp_status_pins
`default_nettype wire

// [verification/rdp_host_model.sv]
// Host controller model driving the serial configuration link
`timescale 1ns/1ps
`default_nettype none

module rdp_host_model (
  // Serial control bus
  output var logic ctl_clk,
  output var logic ctl_en,
  output var logic ctl_data
);
  // ****************************************
  // Frame sender
  // ****************************************
  // Idle: link clock still, frame strobe low
  initial begin
    ctl_clk = 1'b0;
    ctl_en = 1'b0;
    ctl_data = 1'b1;
  end

  // One 16-bit word, bit0 first, 15 ns link clock only inside the frame
  task automatic send(input logic [15:0] w);
    logic [15:0] v;
    v = w;
    v[15:12] = 4'h0;
    ctl_en = 1'b1;
    for (int i = 0; i < 16; i++) begin
      ctl_data = v[i];
      #7.5 ctl_clk = 1'b1;
      #7.5 ctl_clk = 1'b0;
    end
    // Released line shows the inverse, so a stale bit cannot pass
    ctl_data = ~v[15];
    #7.5 ctl_en = 1'b0;
  endtask
endmodule // rdp_host_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the decoder configuration and status pins
`timescale 1ns/1ps
`default_nettype none
`include "rdp_cfg.svh"

module tb
  import rdp_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0; // System clock
  logic srst = 1'b1; // Synchronous reset
  wire logic ctl_clk; // Link from host model
  wire logic ctl_en;
  wire logic ctl_data;
  rdp_core_stat_t st = '0; // Decoder core status
  rdp_core_cfg_t cfg; // Decoded settings
  logic [2:0] ecode; // Block error flags
  logic [`RDP_NPIN-1:0] po;
  logic [`RDP_NPIN-1:0] poe;
  logic [`RDP_NPIN-1:0] lv; // Pin levels with pull-ups
  int error_cnt = 0;
  int cmp_count = 0;

  assign lv = ~poe;
  always #10 clk = ~clk;

  rdp_host_model u_rdp_host_model (.ctl_clk(ctl_clk), .ctl_en(ctl_en), .ctl_data(ctl_data));
  // Short sync pulse keeps the run brief
  rdp_status_pins #(.SYNC_PULSE_CYC(20), .WIN_BLOCKS(48)) u_rdp_status_pins (
    .clk(clk), .srst(srst), .ctl_clk(ctl_clk), .ctl_en(ctl_en), .ctl_data(ctl_data),
    .stat(st), .core_cfg_reg(cfg), .err_code_reg(ecode), .pin_o_reg(po), .pin_oe_reg(poe));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Word: test, mode, {rbds, select, lock, xtal}, decision, limit
  function automatic logic [15:0] cw(input logic [2:0] lim, input logic [1:0] dm,
      input logic [3:0] misc, input logic [2:0] mode);
    return {4'h0, mode, misc, dm, lim};
  endfunction

  // Frame plus margin for the 3-4 cycle crossing
  task automatic wr(input logic [15:0] w);
    u_rdp_host_model.send(w);
    cyc(6);
  endtask

  task automatic pulse(input logic done, input logic start, input logic [3:0] errs);
    st.bit_errs = errs;
    st.block_done = done;
    st.block_start = start;
    cyc(1);
    st.block_done = 1'b0;
    st.block_start = 1'b0;
    cyc(1);
  endtask

  task automatic do_reset();
    srst = 1'b1;
    cyc(3);
    srst = 1'b0;
    cyc(1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults();
    rdp_core_cfg_t e;
    e = '0;
    e.corr_limit = 3'h2;
    e.soft_on = 1'b1;
    e.phase_auto = 1'b1;
    e.phase_zero_deg = 1'b1;
    cyc(2);
    check(16'(cfg), 16'(e));
    check(16'(lv[0]), 16'h0);
    $display("test defaults done");
  endtask

  // Every limit and decision code, other bits varied alongside
  task automatic t_decode();
    rdp_core_cfg_t e;
    logic [2:0] lim;
    logic [1:0] dm;
    logic [3:0] misc;
    for (int i = 0; i < 8; i++) begin
      lim = 3'(i);
      dm = 2'(i + 1);
      misc = {lim[2], ~lim[0], lim[1], lim[0]};
      wr(cw(lim, dm, misc, 3'h3));
      e.corr_limit = lim;
      e.soft_on = dm[0] ^ dm[1];
      e.soft_restrain = (dm == 2'h1);
      e.xtal_fast = misc[0];
      e.phase_auto = ~misc[1];
      e.phase_zero_deg = misc[2];
      e.offset_e_en = misc[3];
      e.illegal = (lim > 3'h5) || (dm == 2'h3);
      check(16'(cfg.illegal), 16'(e.illegal));
      if (!e.illegal) begin
        check(16'(cfg), 16'(e));
      end
    end
    $display("test decode done");
  endtask

  // Pin enables and polarity across all eight output modes
  task automatic t_pins();
    logic [2:0] m;
    logic [6:0] e;
    logic [6:0] k;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr(cw(3'h2, 2'h2, 4'h4, m));
      // Fresh rising data clock per mode, or the data pins would hold
      st.data_clk = 1'b0;
      cyc(1);
      st.data_clk = 1'b1;
      st.sub_clk = 1'b1;
      st.data_bit = m[0];
      st.shift = ~m[0];
      st.traffic = 1'b1;
      st.rds_present = 1'b1;
      cyc(2);
      e = {m[2], ~m[2], 5'h1f};
      k = 7'h67;
      if (m != 3'h0 && m != 3'h4) begin
        e[2:0] = {~m[0], m[0], ~m[2]};
      end
      if (m[1:0] == 2'h1 || m == 3'h0) begin
        k[4:3] = 2'h3;
      end
      if (m[1:0] == 2'h2) begin
        k[4:3] = 2'h3;
        e[4:3] = {m[2], ~m[2]};
      end
      check(16'(lv & k), 16'(e & k));
      check(16'(po), 16'h0);
    end
    $display("test pins done");
  endtask

  // Error flags and mode 3 pins, limit 2 soft B then limit 0 soft A
  task automatic t_err();
    logic [3:0] errs;
    logic [2:0] lim;
    for (int j = 0; j < 2; j++) begin
      lim = j ? 3'h0 : 3'h2;
      wr(cw(lim, 2'h2 >> j, 4'h4, 3'h3));
      for (int n = 0; n < 4; n++) begin
        errs = 4'(n);
        pulse(1'b1, 1'b0, errs);
        cyc(2);
        check(16'(ecode), (errs > 4'(lim)) ? 16'h6 : 16'(errs));
        check(16'(lv[4:3]), {14'h0, errs == 4'h0, errs <= 4'(lim)});
      end
    end
    $display("test errors done");
  endtask

  // Sync pin: mode 3 pulse, then mode 0 level, one block late
  task automatic t_sync();
    wr(cw(3'h2, 2'h2, 4'h4, 3'h3));
    st.in_sync = 1'b1;
    check(16'(lv[5]), 16'h1);
    pulse(1'b1, 1'b0, 4'h0);
    cyc(1);
    check(16'(lv[5]), 16'h0);
    pulse(1'b0, 1'b1, 4'h0);
    cyc(1);
    check(16'(lv[5]), 16'h1);
    cyc(14);
    check(16'(lv[5]), 16'h1);
    cyc(8);
    check(16'(lv[5]), 16'h0);
    wr(cw(3'h2, 2'h2, 4'h4, 3'h0));
    check(16'(lv[5]), 16'h0);
    st.in_sync = 1'b0;
    cyc(2);
    check(16'(lv[5]), 16'h0);
    pulse(1'b1, 1'b0, 4'h0);
    cyc(1);
    check(16'(lv[5]), 16'h1);
    $display("test sync done");
  endtask

  // Errored-block count per 48-block window, one count for each two-bit code
  task automatic t_stats();
    int nb[4] = '{0, 20, 21, 41};
    do_reset();
    wr(cw(3'h2, 2'h2, 4'h4, 3'h4));
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 48; b++) begin
        pulse(1'b1, 1'b0, (b < nb[k]) ? 4'h1 : 4'h0);
      end
      cyc(2);
      check(16'({lv[3], lv[4]}), 16'(k));
    end
    $display("test stats done");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_defaults();
    t_decode();
    t_pins();
    t_err();
    t_sync();
    t_stats();
    end_of_test();
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
